// ### rtl/fzx_pkg.sv
// Package with register map, opcodes and timing constants of the fuzzy execution block
package fzx_pkg;

   // ==============================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CMD      = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_STACK    = 8'h08;
   localparam logic [7:0] OFS_KRES     = 8'h0C;
   localparam logic [7:0] OFS_DIVIDEND = 8'h10;
   localparam logic [7:0] OFS_DIVISOR  = 8'h14;
   localparam logic [7:0] OFS_MASK     = 8'h18;
   localparam logic [7:0] OFS_PRIO     = 8'h1C;
   localparam logic [7:0] OFS_ATM_ADDR = 8'h20;
   localparam logic [7:0] OFS_ATM_DATA = 8'h24;
   localparam logic [7:0] OFS_MBF_LOAD = 8'h28;
   localparam logic [7:0] OFS_VEC_LOAD = 8'h2C;
   localparam logic [7:0] OFS_PENDING  = 8'h30;
   localparam logic [7:0] OFS_SVC_PC   = 8'h34;
   localparam logic [7:0] OFS_RF_BASE  = 8'h80;
   localparam logic [7:0] OFS_RF_LAST  = 8'hBC;

   // ==============================================================
   // Command register fields
   localparam int CMD_OP_LSB  = 0;
   localparam int CMD_DST_LSB = 4;
   localparam int CMD_SRC_LSB = 8;
   localparam int CMD_K_LSB   = 16;

   // Status register bits
   localparam int ST_BUSY   = 0;
   localparam int ST_ZERO   = 1;
   localparam int ST_SIGN   = 2;
   localparam int ST_SVC    = 3;
   localparam int ST_VECOK  = 4;
   localparam int ST_ID_LSB = 8;

   // Membership load fields
   localparam int MBF_LVD_LSB = 0;
   localparam int MBF_VTX_LSB = 8;
   localparam int MBF_RVD_LSB = 16;
   localparam int MBF_FN_LSB  = 24;
   localparam int MBF_VAR_LSB = 28;
   localparam logic [7:0] ATM_VAR_STRIDE = 8'h10;
   localparam logic [7:0] ATM_VTX_OFS    = 8'h40;
   localparam logic [7:0] ATM_RVD_OFS    = 8'h80;

   // Vector load fields
   localparam int VEC_ADDR_LSB = 0;
   localparam int VEC_ID_LSB   = 12;
   localparam int VEC_END_BIT  = 15;

   // ==============================================================
   // Opcodes and execution times in cycles
   typedef enum logic [3:0] {
      OP_NOP   = 4'h0,
      OP_AND   = 4'h1,
      OP_CONS  = 4'h2,
      OP_FZMIN = 4'h3,
      OP_FZMAX = 4'h4,
      OP_MASK  = 4'h5,
      OP_PRIO  = 4'h6
   } fzx_op_e;

   localparam logic [2:0] CYC_AND  = 3'h7;
   localparam logic [2:0] CYC_MASK = 3'h6;
   localparam logic [2:0] CYC_PRIO = 3'h6;
   localparam logic [2:0] CYC_FUZZ = 3'h6;

   // Reset values
   localparam logic [7:0]  MASK_RST = 8'h00;
   localparam logic [7:0]  PRIO_RST = 8'hE4;
   localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } fzx_state_e;

endpackage

// ### rtl/fzx_alu.sv
// Combinational datapath for logical and fuzzy operations
`timescale 1ns/1ns
module fzx_alu #(
   parameter int W = 8
) (
   // Operands
   input  wire logic [W-1:0]   op_a,
   input  wire logic [W-1:0]   op_b,
   // Results
   output logic      [W-1:0]   and_res,
   output logic                and_zero,
   output logic      [W-1:0]   min_res,
   output logic      [W-1:0]   max_res,
   output logic      [2*W-1:0] prod_res
);
   initial begin
      if (W < 1) $error("fzx_alu width must be positive");
   end

   always_comb begin
      and_res  = op_a & op_b;
      and_zero = ~|(op_a & op_b);
      min_res  = (op_a < op_b) ? op_a : op_b;
      max_res  = (op_a > op_b) ? op_a : op_b;
      prod_res = op_a * op_b;
   end
endmodule

// ### rtl/fzx_exec.sv
// Execution unit for logical AND, fuzzy operations and interrupt control
// Functional notes
// - A logical AND of source and destination registers is written to the destination in 7 cycles.
// - The logical AND sets the zero flag on a zero result, clears it otherwise, sign untouched.
// - Consequent adds constant times truth value to the dividend and truth value to the divisor.
// - The truth value is the latest fuzzy result and the constant is the singleton output value.
// - Membership data sit at 16*var+fn, vertex 64 above, right distance 128 above.
// - Membership data are placed in the antecedent memory only by loading, never by execution.
// - Fuzzy AND takes the minimum of both stack entries into the fuzzy result register.
// - Fuzzy OR takes the maximum of both stack entries into the fuzzy result register.
// - Servicing an interrupt loads the program counter with that interrupt's vector.
// - Vectors are stored as data only, and a run of them is closed by an end entry.
// - The mask load writes the mask register, bit n enabling interrupt n, in 6 cycles.
// - The priority load writes an 8-bit register of two-bit fields, each field distinct; the value is written as given, without a check.
`timescale 1ns/1ns
module fzx_exec #(
   parameter int NUM_IRQ = 4,
   parameter int PC_W    = 11,
   parameter int ACC_W   = 24
) (
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 nrst,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Interrupt pins and service
   input  wire logic [NUM_IRQ-1:0]   irq_pin,
   output logic      [PC_W-1:0]      svc_pc,
   output logic                      svc_active,
   output logic      [1:0]           svc_id
);
   initial begin
      if (NUM_IRQ != 4) $error("fzx_exec priority register serves exactly 4 interrupts");
      if (PC_W < 1 || PC_W > 12) $error("fzx_exec PC_W out of range");
      if (ACC_W < 16 || ACC_W > 32) $error("fzx_exec ACC_W out of range");
   end

   // ==============================================================
   // Declarations
   logic [7:0]         rf_q [16];
   logic [7:0]         atm_q [256];
   logic [PC_W-1:0]    vec_q [NUM_IRQ];
   logic [7:0]         stack0_q, stack1_q, kres_q, mask_q, prio_q, atm_addr_q;
   logic [ACC_W-1:0]   dividend_q, divisor_q;
   logic               zero_q, sign_q, vec_ok_q;
   fzx_pkg::fzx_state_e state_q;
   fzx_pkg::fzx_op_e   op_q;
   logic [3:0]         dst_q, src_q;
   logic [7:0]         konst_q;
   logic [2:0]         cnt_q;
   logic [NUM_IRQ-1:0] irq_s1_q, irq_s2_q, irq_s3_q, pend_q;
   logic [31:0]        rd_data;
   logic               rd_err;
   logic               acc_ph, wr_go, cmd_wr, cmd_ok, done, mul_sel;
   logic [7:0]         and_res, min_res, max_res;
   logic               and_zero;
   logic [15:0]        prod_res;
   logic               take;
   logic [1:0]         take_id;
   logic [1:0]         best_lvl;
   logic [7:0]         mbf_base;

   // ==============================================================
   // APB handshake: one wait state, write lands at the pready edge
   assign acc_ph = psel & penable;
   assign wr_go  = acc_ph & pready & pwrite;
   assign cmd_wr = wr_go & (paddr == fzx_pkg::OFS_CMD);
   assign cmd_ok = (state_q == fzx_pkg::ST_IDLE) && (pwdata[3:0] != 4'h0) &&
                   (pwdata[3:0] <= 4'h6);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= fzx_pkg::RD_ZERO;
      end else begin
         pready  <= acc_ph & ~pready;
         pslverr <= acc_ph & ~pready & rd_err;
         if (acc_ph && !pready && !pwrite) begin
            prdata <= rd_data;
         end
      end
   end

   // Unmapped addresses and refused commands both answer with an error
   always_comb begin
      rd_data = fzx_pkg::RD_ZERO;
      rd_err  = 1'b0;
      if (paddr >= fzx_pkg::OFS_RF_BASE && paddr <= fzx_pkg::OFS_RF_LAST &&
          paddr[1:0] == 2'b00) begin
         rd_data[7:0] = rf_q[paddr[5:2]];
      end else begin
         case (paddr)
            fzx_pkg::OFS_CMD: begin
               rd_err = pwrite && !cmd_ok;
            end
            fzx_pkg::OFS_STATUS: begin
               rd_data[fzx_pkg::ST_BUSY]  = (state_q == fzx_pkg::ST_EXEC);
               rd_data[fzx_pkg::ST_ZERO]  = zero_q;
               rd_data[fzx_pkg::ST_SIGN]  = sign_q;
               rd_data[fzx_pkg::ST_SVC]   = svc_active;
               rd_data[fzx_pkg::ST_VECOK] = vec_ok_q;
               rd_data[fzx_pkg::ST_ID_LSB +: 2] = svc_id;
            end
            fzx_pkg::OFS_STACK:    rd_data[15:0] = {stack1_q, stack0_q};
            fzx_pkg::OFS_KRES:     rd_data[7:0] = kres_q;
            fzx_pkg::OFS_DIVIDEND: rd_data[ACC_W-1:0] = dividend_q;
            fzx_pkg::OFS_DIVISOR:  rd_data[ACC_W-1:0] = divisor_q;
            fzx_pkg::OFS_MASK:     rd_data[7:0] = mask_q;
            fzx_pkg::OFS_PRIO:     rd_data[7:0] = prio_q;
            fzx_pkg::OFS_ATM_ADDR: rd_data[7:0] = atm_addr_q;
            fzx_pkg::OFS_ATM_DATA: rd_data[7:0] = atm_q[atm_addr_q];
            fzx_pkg::OFS_MBF_LOAD: rd_data = fzx_pkg::RD_ZERO;
            fzx_pkg::OFS_VEC_LOAD: rd_data = fzx_pkg::RD_ZERO;
            fzx_pkg::OFS_PENDING:  rd_data[NUM_IRQ-1:0] = pend_q;
            fzx_pkg::OFS_SVC_PC:   rd_data[PC_W-1:0] = svc_pc;
            default:               rd_err = 1'b1;
         endcase
      end
   end

   // ==============================================================
   // Datapath
   fzx_alu #(
      .W (8)
   ) u_alu (
      .op_a     (op_q == fzx_pkg::OP_AND ? rf_q[dst_q] : (mul_sel ? konst_q : stack0_q)),
      .op_b     (op_q == fzx_pkg::OP_AND ? rf_q[src_q] : (mul_sel ? kres_q : stack1_q)),
      .and_res  (and_res),
      .and_zero (and_zero),
      .min_res  (min_res),
      .max_res  (max_res),
      .prod_res (prod_res)
   );

   // ==============================================================
   // Instruction sequencer
   assign done = (state_q == fzx_pkg::ST_EXEC) && (cnt_q == 3'h1);
   assign mul_sel = (op_q == fzx_pkg::OP_CONS);
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= fzx_pkg::ST_IDLE;
         op_q    <= fzx_pkg::OP_NOP;
         dst_q   <= 4'h0;
         src_q   <= 4'h0;
         konst_q <= 8'h00;
         cnt_q   <= 3'h0;
      end else begin
         case (state_q)
            fzx_pkg::ST_IDLE: begin
               if (cmd_wr && cmd_ok) begin
                  op_q    <= fzx_pkg::fzx_op_e'(pwdata[fzx_pkg::CMD_OP_LSB +: 4]);
                  dst_q   <= pwdata[fzx_pkg::CMD_DST_LSB +: 4];
                  src_q   <= pwdata[fzx_pkg::CMD_SRC_LSB +: 4];
                  konst_q <= pwdata[fzx_pkg::CMD_K_LSB +: 8];
                  state_q <= fzx_pkg::ST_EXEC;
                  case (pwdata[3:0])
                     4'h1:    cnt_q <= fzx_pkg::CYC_AND;
                     4'h5:    cnt_q <= fzx_pkg::CYC_MASK;
                     4'h6:    cnt_q <= fzx_pkg::CYC_PRIO;
                     default: cnt_q <= fzx_pkg::CYC_FUZZ;
                  endcase
               end
            end
            fzx_pkg::ST_EXEC: begin
               cnt_q <= cnt_q - 3'h1;
               if (done) begin
                  state_q <= fzx_pkg::ST_IDLE;
               end
            end
            default: state_q <= fzx_pkg::ST_IDLE;
         endcase
      end
   end

   // Register file: software access and AND write-back
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 16; i++) begin
            rf_q[i] <= 8'h00;
         end
      end else if (done && op_q == fzx_pkg::OP_AND) begin
         rf_q[dst_q] <= and_res;
      end else if (wr_go && paddr[7] && !rd_err) begin
         rf_q[paddr[5:2]] <= pwdata[7:0];
      end
   end

   // Flags; sign is never touched by this block
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         zero_q <= 1'b0;
         sign_q <= 1'b0;
      end else if (done && op_q == fzx_pkg::OP_AND) begin
         zero_q <= and_zero;
      end
   end

   // Fuzzy stack and result register
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stack0_q <= 8'h00;
         stack1_q <= 8'h00;
         kres_q   <= 8'h00;
      end else begin
         if (wr_go && paddr == fzx_pkg::OFS_STACK && state_q == fzx_pkg::ST_IDLE) begin
            stack0_q <= pwdata[7:0];
            stack1_q <= pwdata[15:8];
         end
         if (done && op_q == fzx_pkg::OP_FZMIN) begin
            kres_q <= min_res;
         end else if (done && op_q == fzx_pkg::OP_FZMAX) begin
            kres_q <= max_res;
         end
      end
   end

   // Defuzzification accumulators; a write to either clears both unless a consequent completes in that cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dividend_q <= '0;
         divisor_q  <= '0;
      end else if (done && op_q == fzx_pkg::OP_CONS) begin
         // Truth value is the latest fuzzy result, not the stack
         dividend_q <= dividend_q + ACC_W'(prod_res);
         divisor_q  <= divisor_q + ACC_W'(kres_q);
      end else if (wr_go && (paddr == fzx_pkg::OFS_DIVIDEND || paddr == fzx_pkg::OFS_DIVISOR)) begin
         dividend_q <= '0;
         divisor_q  <= '0;
      end
   end

   // Mask and priority loads
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mask_q <= fzx_pkg::MASK_RST;
         prio_q <= fzx_pkg::PRIO_RST;
      end else if (done && op_q == fzx_pkg::OP_MASK) begin
         mask_q <= konst_q;
      end else if (done && op_q == fzx_pkg::OP_PRIO) begin
         prio_q <= konst_q;
      end
   end

   // ==============================================================
   // Antecedent table memory, filled only through the load port
   assign mbf_base = 8'(pwdata[fzx_pkg::MBF_VAR_LSB +: 2] * fzx_pkg::ATM_VAR_STRIDE) +
                     {4'h0, pwdata[fzx_pkg::MBF_FN_LSB +: 4]};

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         atm_addr_q <= 8'h00;
      end else if (wr_go && paddr == fzx_pkg::OFS_ATM_ADDR) begin
         atm_addr_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (wr_go && paddr == fzx_pkg::OFS_MBF_LOAD) begin
         atm_q[mbf_base]                          <= pwdata[fzx_pkg::MBF_LVD_LSB +: 8];
         atm_q[8'(mbf_base + fzx_pkg::ATM_VTX_OFS)] <= pwdata[fzx_pkg::MBF_VTX_LSB +: 8];
         atm_q[8'(mbf_base + fzx_pkg::ATM_RVD_OFS)] <= pwdata[fzx_pkg::MBF_RVD_LSB +: 8];
      end
   end

   // ==============================================================
   // Vector table; service stays off until the end entry arrives
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         vec_ok_q <= 1'b0;
         for (int i = 0; i < NUM_IRQ; i++) begin
            vec_q[i] <= '0;
         end
      end else if (wr_go && paddr == fzx_pkg::OFS_VEC_LOAD) begin
         if (pwdata[fzx_pkg::VEC_END_BIT]) begin
            vec_ok_q <= 1'b1;
         end else begin
            vec_ok_q <= 1'b0;
            vec_q[pwdata[fzx_pkg::VEC_ID_LSB +: 2]] <= pwdata[fzx_pkg::VEC_ADDR_LSB +: PC_W];
         end
      end
   end

   // Pin synchroniser and rising-edge capture
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         irq_s1_q <= '0;
         irq_s2_q <= '0;
         irq_s3_q <= '0;
      end else begin
         irq_s1_q <= irq_pin;
         irq_s2_q <= irq_s1_q;
         irq_s3_q <= irq_s2_q;
      end
   end

   // Lowest field value wins among enabled pending lines
   always_comb begin
      take     = 1'b0;
      take_id  = 2'h0;
      best_lvl = 2'h3;
      for (int i = 0; i < NUM_IRQ; i++) begin
         if (pend_q[i] && mask_q[i] && (!take || prio_q[2*i +: 2] < best_lvl)) begin
            take     = 1'b1;
            take_id  = 2'(i);
            best_lvl = prio_q[2*i +: 2];
         end
      end
      take = take & vec_ok_q & ~svc_active & (state_q == fzx_pkg::ST_IDLE);
   end

   // New edge wins over the clear on acceptance
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q & ~(take ? NUM_IRQ'(1) << take_id : '0)) | (irq_s2_q & ~irq_s3_q);
      end
   end

   // Service entry; a write to the pending register ends service
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         svc_pc     <= '0;
         svc_active <= 1'b0;
         svc_id     <= 2'h0;
      end else if (take) begin
         svc_pc     <= vec_q[take_id];
         svc_active <= 1'b1;
         svc_id     <= take_id;
      end else if (wr_go && paddr == fzx_pkg::OFS_PENDING) begin
         svc_active <= 1'b0;
      end
   end

endmodule

// ### tb/fzx_exec_checker.sv
// Port-level assertions for the fuzzy execution block
`timescale 1ns/1ns
module fzx_exec_checker #(
   parameter int NUM_IRQ = 4,
   parameter int PC_W    = 11
) (
   // Clock and reset
   input wire logic            clk_sys,
   input wire logic            nrst,
   // APB
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [7:0]      paddr,
   input wire logic [31:0]     pwdata,
   input wire logic            pready,
   input wire logic            pslverr,
   // Service
   input wire logic [PC_W-1:0] svc_pc,
   input wire logic            svc_active,
   input wire logic [1:0]      svc_id
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ==============================================================
   // Bus phases
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable; endsequence
   sequence s_done; psel && penable && pready; endsequence
   // ==============================================================
   // Assertions
   AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
      else $error("ready not one cycle after first access");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_UNMAPPED: assert property (s_done ##0 ((paddr > 8'h34 && paddr < 8'h80)
      || paddr > 8'hBC) |-> pslverr) else $error("unmapped access not refused");
   AST_BAD_OPCODE: assert property (s_done ##0 (pwrite && paddr == fzx_pkg::OFS_CMD
      && (pwdata[3:0] == 4'h0 || pwdata[3:0] > 4'h6)) |-> pslverr)
      else $error("bad opcode not refused");
   AST_RF_OK: assert property (s_done ##0 (paddr >= fzx_pkg::OFS_RF_BASE
      && paddr <= fzx_pkg::OFS_RF_LAST && paddr[1:0] == 2'b00) |-> !pslverr)
      else $error("register file access refused");
   AST_SVC_HOLD: assert property (svc_active && $past(svc_active)
      |-> $stable(svc_id) && $stable(svc_pc)) else $error("service target moved");
   AST_SVC_END: assert property ($fell(svc_active)
      |-> $past(pready && pwrite && paddr == fzx_pkg::OFS_PENDING))
      else $error("service ended without pending write");
endmodule
bind fzx_exec fzx_exec_checker #(.NUM_IRQ(NUM_IRQ), .PC_W(PC_W)) i_fzx_exec_checker (
   .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .svc_pc(svc_pc), .svc_active(svc_active), .svc_id(svc_id));

// ### tb/tb_fzx_exec.sv
// Self-checking testbench for the fuzzy execution block
`timescale 1ns/1ns
module tb_fzx_exec;
   // ==============================================================
   // Signals and model state
   logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr, svc_active, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  irq_pin;
   logic [10:0] svc_pc;
   logic [1:0]  svc_id;
   int          fail_count, cmp_count, rf[16], vec[4], k, dvd, dvs, a, b, x, i, n;

   fzx_exec i_fzx_exec (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_pin(irq_pin), .svc_pc(svc_pc), .svc_active(svc_active),
      .svc_id(svc_id));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // ==============================================================
   // Tasks
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Request held until the edge that samples ready
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      if (n >= 20) chk(0, 1, "no ready");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e,
                      input string s);
      apb(1'b0, ad, 32'h0);
      chk(rd & m, e, s);
   endtask

   // Leaves the final status word in rd
   task automatic run(input logic [3:0] op, input int d, input int s, input int kk);
      apb(1'b1, fzx_pkg::OFS_CMD, {8'h00, kk[7:0], 4'h0, s[3:0], d[3:0], op});
      apb(1'b0, fzx_pkg::OFS_STATUS, 32'h0);
      chk(rd[0], 1, "busy after command");
      for (int t = 0; t < 10 && rd[0] === 1'b1; t++) apb(1'b0, fzx_pkg::OFS_STATUS, 0);
      chk(rd[0], 0, "busy at end");
   endtask
   // ==============================================================
   // Watchdog, far longer than the tests need
   initial begin
      repeat (30000) @(posedge clk_sys);
      fail_count++;
      tally_and_finish();
   end
   // ==============================================================
   // Tests
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      irq_pin = 4'h0;
      fail_count = 0;
      cmp_count = 0;
      void'($urandom(32'h7783D404));
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      rdc(fzx_pkg::OFS_MASK, 32'hFFFFFFFF, 32'h00, "mask reset");
      rdc(fzx_pkg::OFS_PRIO, 32'hFFFFFFFF, 32'hE4, "prio reset");
      $display("test reset done");
      for (i = 0; i < 16; i++) begin
         rf[i] = $urandom % 256;
         apb(1'b1, 8'h80 + 8'(4 * i), rf[i]);
      end
      // First two cases fixed: a known pattern, then a zero result
      for (i = 0; i < 8; i++) begin
         a = (i < 2) ? 4 + i : $urandom % 16;
         b = (i < 2) ? 12 - 6 * i : $urandom % 16;
         if (i < 2) begin
            rf[a] = i ? 8'h0F : 8'h9C;
            rf[b] = i ? 8'hF0 : 8'h55;
            apb(1'b1, 8'h80 + 8'(4 * a), rf[a]);
            apb(1'b1, 8'h80 + 8'(4 * b), rf[b]);
         end
         run(fzx_pkg::OP_AND, a, b, 0);
         rf[a] = rf[a] & rf[b];
         chk(rd[2:1], {1'b0, rf[a] == 0}, "zero and sign");
         rdc(8'h80 + 8'(4 * a), 32'hFFFFFFFF, rf[a], "and result");
      end
      $display("test and done");
      dvd = 0;
      dvs = 0;
      apb(1'b1, fzx_pkg::OFS_DIVIDEND, 32'h0);
      for (i = 0; i < 6; i++) begin
         a = $urandom % 256;
         b = $urandom % 256;
         x = $urandom % 256;
         apb(1'b1, fzx_pkg::OFS_STACK, {16'h0, b[7:0], a[7:0]});
         run(i[0] ? fzx_pkg::OP_FZMAX : fzx_pkg::OP_FZMIN, 0, 0, 0);
         k = i[0] ? (a > b ? a : b) : (a < b ? a : b);
         rdc(fzx_pkg::OFS_KRES, 32'hFF, k, "fuzzy result");
         run(fzx_pkg::OP_CONS, 0, 0, x);
         dvd += x * k;
         dvs += k;
         rdc(fzx_pkg::OFS_DIVIDEND, 32'hFFFFFF, dvd, "dividend");
         rdc(fzx_pkg::OFS_DIVISOR, 32'hFFFF, dvs, "divisor");
      end
      $display("test fuzzy done");
      for (i = 0; i < 4; i++) begin
         x = $urandom;
         a = 16 * x[29:28] + x[27:24];
         apb(1'b1, fzx_pkg::OFS_MBF_LOAD, {2'b00, x[29:0]});
         rdc(fzx_pkg::OFS_STATUS, 32'h1, 32'h0, "load not executed");
         for (int j = 0; j < 3; j++) begin
            apb(1'b1, fzx_pkg::OFS_ATM_ADDR, a + 64 * j);
            rdc(fzx_pkg::OFS_ATM_DATA, 32'hFF, (x >> (8 * j)) & 255, "membership");
         end
      end
      $display("test membership done");
      run(fzx_pkg::OP_MASK, 0, 0, 10);
      rdc(fzx_pkg::OFS_MASK, 32'hFFFFFFFF, 32'd10, "mask");
      run(fzx_pkg::OP_PRIO, 0, 0, 198);
      rdc(fzx_pkg::OFS_PRIO, 32'hFFFFFFFF, 32'd198, "priority");
      for (i = 0; i < 4; i++) begin
         vec[i] = $urandom % 2048;
         apb(1'b1, fzx_pkg::OFS_VEC_LOAD, {16'h0, 2'b00, i[1:0], 1'b0, vec[i][10:0]});
      end
      irq_pin <= 4'hF;
      repeat (12) @(posedge clk_sys);
      chk(svc_active, 0, "table still open");
      apb(1'b1, fzx_pkg::OFS_VEC_LOAD, 32'h8000);
      // Only 1 and 3 enabled; 1 has the smaller field
      for (i = 1; i < 4; i += 2) begin
         n = 0;
         while (svc_active !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
         end
         chk(svc_id, i, "service id");
         chk(svc_pc, vec[i], "service pc");
         apb(1'b1, fzx_pkg::OFS_PENDING, 32'h0);
         @(posedge clk_sys);
      end
      irq_pin <= 4'h0;
      repeat (12) @(posedge clk_sys);
      chk(svc_active, 0, "masked pins");
      $display("test interrupt done");
      for (i = 0; i < 3; i++) begin
         apb(1'b1, (i == 0) ? 8'hC0 : 8'h00, (i == 2) ? 32'h7 : 32'h0);
         chk(er, 1, "refused access");
      end
      $display("test refusal done");
      tally_and_finish();
   end
endmodule
